// *** plr_pkg.sv ***
// plr_pkg: constants for the hypervisor and monitor partition-label registers
// assumes: used by plr_regs and plr_core_model; referenced as plr_pkg::name only
package plr_pkg;

  // system-register encoding fields
  localparam logic [1:0] ENC_OP0        = 2'h3;  // op0 11
  localparam logic [3:0] ENC_CRN        = 4'hA;  // CRn 1010
  localparam logic [3:0] ENC_CRM        = 4'h5;  // CRm 0101
  localparam logic [2:0] ENC_OP2_LABEL  = 3'h0;  // op2 000
  localparam logic [2:0] ENC_OP2_USER   = 3'h1;  // op2 of user-level register, plain default
  localparam logic [2:0] ENC_OP1_LOWER  = 3'h0;  // op1 of kernel and user registers
  localparam logic [2:0] ENC_OP1_HYP    = 3'h4;  // op1 100
  localparam logic [2:0] ENC_OP1_MON    = 3'h6;  // op1 110

  // exception levels
  localparam logic [1:0] EL0            = 2'h0;
  localparam logic [1:0] EL1            = 2'h1;
  localparam logic [1:0] EL2            = 2'h2;
  localparam logic [1:0] EL3            = 2'h3;

  // field positions
  localparam int         BIT_ENABLE     = 63;
  localparam int         BIT_FORCE_TRAP = 62;
  localparam int         BIT_TRAP_USER  = 49;
  localparam int         BIT_TRAP_KERN  = 48;
  localparam int         DPMG_HI        = 47;
  localparam int         DPMG_LO        = 40;
  localparam int         IPMG_HI        = 39;
  localparam int         IPMG_LO        = 32;
  localparam int         DPID_HI        = 31;
  localparam int         DPID_LO        = 16;
  localparam int         IPID_HI        = 15;
  localparam int         IPID_LO        = 0;
  localparam int         FIELD_W        = 48;  // bits 47..0 hold groups and ids

  // reserved spans
  localparam logic [12:0] HYP_RSVD      = 13'h0000;  // bits 62..50
  localparam logic [13:0] MON_RSVD      = 14'h0000;  // bits 61..48

  // values after reset
  localparam logic        RST_ENABLE     = 1'h0;
  localparam logic        RST_FORCE_TRAP = 1'h1;
  localparam logic        RST_TRAP_USER  = 1'h1;
  localparam logic        RST_TRAP_KERN  = 1'h1;
  localparam logic [47:0] RST_FIELDS     = 48'h0000_0000_0000;
  localparam logic [1:0]  RST_SYNC       = 2'h0;

  // default labels carried while labelling is off
  localparam logic [15:0] DEF_PID        = 16'h0000;
  localparam logic [7:0]  DEF_PMG        = 8'h00;

endpackage : plr_pkg

// *** plr_label_store.sv ***
// plr_label_store: one write-enabled storage word with a constant reset value
// assumes: synchronous write strobe on sys_clk; rst_n already synchronised
`timescale 1ns/100ps
`default_nettype none

module plr_label_store #(
  parameter int          W   = 48,
  parameter logic [47:0] RST = 48'h0000_0000_0000
) (
  input  wire logic         sys_clk,  // core clock
  input  wire logic         rst_n,    // synchronised reset, active low
  input  wire logic         wr_en,    // one-cycle write strobe
  input  wire logic [W-1:0] wdata,    // value to store
  output logic      [W-1:0] q         // stored value
);

  // stored word; reset takes the constant only
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= RST[W-1:0];
    end else if (wr_en) begin
      q <= wdata;
    end
  end

endmodule : plr_label_store
`default_nettype wire

// *** plr_regs.sv ***
// plr_regs: hypervisor and monitor partition-label registers, access checks and label selection
// assumes: the core presents one system-register move at a time as a one-cycle request;
// the lower-level label registers live elsewhere and their selected fields come in on lower_fields
//
// Notes on behaviour
// - enable low forces default labels everywhere
// - enable bit is one shared storage bit
// - hypervisor enable writable only without monitor level
// - enable resets to zero
// - hypervisor bit 49 traps EL1 user-register access
// - hypervisor bit 48 traps EL1 kernel-register access
// - both hypervisor trap bits reset to one
// - monitoring groups in bits 47..40, 39..32
// - hypervisor ids label EL2 data and fetches
// - monitor ids label EL3 data and fetches
// - hypervisor register idle when EL2 disabled
// - monitor enable always readable and writable
// - monitor bit 62 forces lower accesses to EL3
// - force-trap bit resets to one
// - forced trap covers EL2 and nested EL1
// - nested EL1 hypervisor access traps to EL2
// - decode op0 CRn CRm op2, op1 selects
// - access levels per register enforced
// - without extension every access is undefined
// - reset values assume 64-bit reset level
`timescale 1ns/100ps
`default_nettype none

module plr_regs #(
  parameter bit EXT_IMPL = 1'b1,  // partitioning extension present
  parameter bit EL2_IMPL = 1'b1,  // hypervisor level present
  parameter bit EL3_IMPL = 1'b1   // monitor level present
) (
  input  wire logic        sys_clk,                  // core clock, 50 MHz
  input  wire logic        resetn,                   // cold reset, active low, async
  input  wire logic        req_valid,                // one-cycle system-register move
  input  wire logic        req_write,                // 1 write, 0 read
  input  wire logic [1:0]  req_el,                   // level issuing the move
  input  wire logic [1:0]  req_op0,                  // encoding fields
  input  wire logic [2:0]  req_op1,
  input  wire logic [3:0]  req_crn,
  input  wire logic [3:0]  req_crm,
  input  wire logic [2:0]  req_op2,
  input  wire logic [63:0] req_wdata,                // write data
  input  wire logic        nonsecure_state,          // current security state is nonsecure
  input  wire logic        secure_hypervisor_enable, // secure EL2 enabled
  input  wire logic        el2_uses_64,              // EL2 runs 64-bit
  input  wire logic        host_in_hypervisor_mode,
  input  wire logic        nested_virtualization,
  input  wire logic        nested_virt_redirect,
  input  wire logic [1:0]  cur_el,                   // level now executing, for labels
  input  wire logic [47:0] lower_fields,             // groups and ids of selected lower register
  output logic             resp_valid,               // answer strobe, one cycle after request
  output logic             resp_undef,               // undefined instruction
  output logic             resp_trap_el2,            // trap taken to EL2
  output logic             resp_trap_el3,            // trap taken to EL3
  output logic             resp_lower_pass,          // lower register access may proceed
  output logic [63:0]      resp_rdata,               // read data, zero unless a read here
  output logic             label_enable,             // shared enable bit
  output logic [15:0]      data_partition_id,        // label for data requests
  output logic [15:0]      instr_partition_id,       // label for fetches
  output logic [7:0]       data_monitor_group,
  output logic [7:0]       instr_monitor_group
);

  // ---------------------------------------------------------------- reset
  logic [1:0] rst_sync_q;  // release synchroniser
  logic       rst_n;       // synchronised reset used everywhere else

  // two-stage release so the rest sees a clean deassertion
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rst_sync_q <= plr_pkg::RST_SYNC;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // ---------------------------------------------------------------- state
  logic        label_enable_q;  // the single shared enable bit
  logic        force_trap_q;    // monitor force-trap bit
  logic        trap_user_q;     // trap_user_label_reg_access
  logic        trap_kern_q;     // trap_kernel_label_reg_access
  logic [47:0] hyp_fields;      // hypervisor groups and ids
  logic [47:0] mon_fields;      // monitor groups and ids
  logic        ft;              // effective force-trap, zero without monitor level

  // ---------------------------------------------------------------- decode
  logic enc_base;   // common op0, CRn, CRm
  logic enc_hyp;    // hypervisor register
  logic enc_mon;    // monitor register
  logic enc_kern;   // kernel-level register
  logic enc_user;   // user-level register
  logic enc_hit;    // any of the four
  logic alias_hyp;  // kernel name at EL2 with host mode reaches the hypervisor register
  logic el2_en;     // EL2 enabled in current security state
  logic el2_ctx;    // EL2 enabled and 64-bit

  assign enc_base  = (req_op0 == plr_pkg::ENC_OP0) && (req_crn == plr_pkg::ENC_CRN)
                     && (req_crm == plr_pkg::ENC_CRM);
  assign enc_hyp   = enc_base && (req_op1 == plr_pkg::ENC_OP1_HYP)
                     && (req_op2 == plr_pkg::ENC_OP2_LABEL);
  assign enc_mon   = enc_base && (req_op1 == plr_pkg::ENC_OP1_MON)
                     && (req_op2 == plr_pkg::ENC_OP2_LABEL);
  assign enc_kern  = enc_base && (req_op1 == plr_pkg::ENC_OP1_LOWER)
                     && (req_op2 == plr_pkg::ENC_OP2_LABEL);
  assign enc_user  = enc_base && (req_op1 == plr_pkg::ENC_OP1_LOWER)
                     && (req_op2 == plr_pkg::ENC_OP2_USER);
  assign enc_hit   = enc_hyp || enc_mon || enc_kern || enc_user;
  assign alias_hyp = enc_kern && (req_el == plr_pkg::EL2) && host_in_hypervisor_mode;
  assign el2_en    = EL2_IMPL && (nonsecure_state || secure_hypervisor_enable);
  assign el2_ctx   = el2_en && el2_uses_64;
  assign ft        = EL3_IMPL && force_trap_q;

  // ---------------------------------------------------------------- access decision
  logic dec_undef;  // undefined
  logic dec_el3;    // trap to EL3
  logic dec_el2;    // trap to EL2
  logic dec_pass;   // lower register access proceeds elsewhere
  logic dec_hyp;    // hypervisor register access proceeds here
  logic dec_mon;    // monitor register access proceeds here

  // priority: undefined, then trap to EL3, then trap to EL2, then execute
  always_comb begin
    dec_undef = 1'b0;
    dec_el3   = 1'b0;
    dec_el2   = 1'b0;
    dec_pass  = 1'b0;
    dec_hyp   = 1'b0;
    dec_mon   = 1'b0;
    if (!EXT_IMPL) begin
      dec_undef = 1'b1;
    end else if (enc_hyp || alias_hyp) begin
      if (!EL2_IMPL) begin
        dec_undef = 1'b1;
      end else begin
        unique case (req_el)
          plr_pkg::EL3: dec_hyp = 1'b1;
          plr_pkg::EL2: begin
            dec_el3 = ft;
            dec_hyp = !ft;
          end
          plr_pkg::EL1: begin
            // nested hypervisors reach this register only through traps
            if (ft && nested_virtualization && !nested_virt_redirect) begin
              dec_el3 = 1'b1;
            end else if (!ft && el2_ctx && host_in_hypervisor_mode && nested_virtualization
                         && !nested_virt_redirect) begin
              dec_el2 = 1'b1;
            end else begin
              dec_undef = 1'b1;
            end
          end
          plr_pkg::EL0: dec_undef = 1'b1;
        endcase
      end
    end else if (enc_mon) begin
      // below EL3 the monitor register is undefined, so the force-trap never applies
      dec_undef = !EL3_IMPL || (req_el != plr_pkg::EL3);
      dec_mon   = EL3_IMPL && (req_el == plr_pkg::EL3);
    end else if (enc_kern) begin
      unique case (req_el)
        plr_pkg::EL3: dec_pass = 1'b1;
        plr_pkg::EL2: begin
          dec_el3  = ft;
          dec_pass = !ft;
        end
        plr_pkg::EL1: begin
          if (ft && (!nested_virtualization || !nested_virt_redirect)) begin
            dec_el3 = 1'b1;
          end else if (!ft && el2_ctx && ((trap_kern_q && !nested_virtualization)
                       || (!trap_kern_q && nested_virtualization && !nested_virt_redirect))) begin
            dec_el2 = 1'b1;
          end else begin
            dec_pass = 1'b1;
          end
        end
        plr_pkg::EL0: dec_undef = 1'b1;
      endcase
    end else if (enc_user) begin
      unique case (req_el)
        plr_pkg::EL3: dec_pass = 1'b1;
        plr_pkg::EL2, plr_pkg::EL1: begin
          if (ft) begin
            dec_el3 = 1'b1;
          end else if ((req_el == plr_pkg::EL1) && el2_ctx && trap_user_q) begin
            dec_el2 = 1'b1;
          end else begin
            dec_pass = 1'b1;
          end
        end
        plr_pkg::EL0: dec_undef = 1'b1;
      endcase
    end
  end

  // ---------------------------------------------------------------- writes
  logic fire;    // a request to one of our encodings
  logic hyp_wr;  // hypervisor register write executes
  logic mon_wr;  // monitor register write executes

  assign fire   = req_valid && enc_hit;
  assign hyp_wr = fire && req_write && dec_hyp;
  assign mon_wr = fire && req_write && dec_mon;

  // shared enable: one bit, written from the monitor register, or from the
  // hypervisor register only when no monitor level exists
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      label_enable_q <= plr_pkg::RST_ENABLE;
    end else if (mon_wr) begin
      label_enable_q <= req_wdata[plr_pkg::BIT_ENABLE];
    end else if (hyp_wr && !EL3_IMPL) begin
      label_enable_q <= req_wdata[plr_pkg::BIT_ENABLE];
    end
  end

  // force-trap bit, held only with a monitor level
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      force_trap_q <= plr_pkg::RST_FORCE_TRAP;
    end else if (mon_wr) begin
      force_trap_q <= req_wdata[plr_pkg::BIT_FORCE_TRAP];
    end
  end

  // lower-level trap bits; reset to one even where the value may be left open
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      trap_user_q <= plr_pkg::RST_TRAP_USER;
      trap_kern_q <= plr_pkg::RST_TRAP_KERN;
    end else if (hyp_wr) begin
      trap_user_q <= req_wdata[plr_pkg::BIT_TRAP_USER];
      trap_kern_q <= req_wdata[plr_pkg::BIT_TRAP_KERN];
    end
  end

  // group and id fields of each register; reserved bits are never stored
  plr_label_store #(
    .W   (plr_pkg::FIELD_W),
    .RST (plr_pkg::RST_FIELDS)
  ) u_hyp_store (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .wr_en   (hyp_wr),
    .wdata   (req_wdata[47:0]),
    .q       (hyp_fields)
  );

  plr_label_store #(
    .W   (plr_pkg::FIELD_W),
    .RST (plr_pkg::RST_FIELDS)
  ) u_mon_store (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .wr_en   (mon_wr),
    .wdata   (req_wdata[47:0]),
    .q       (mon_fields)
  );

  // ---------------------------------------------------------------- answer
  logic [63:0] rd_d;  // read value for this request

  // read image; reserved spans read zero
  always_comb begin
    rd_d = 64'h0000_0000_0000_0000;
    if (!req_write && dec_hyp) begin
      rd_d = {label_enable_q, plr_pkg::HYP_RSVD, trap_user_q, trap_kern_q, hyp_fields};
    end else if (!req_write && dec_mon) begin
      rd_d = {label_enable_q, ft, plr_pkg::MON_RSVD, mon_fields};
    end
  end

  // registered answer one cycle after each request to our encodings
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      resp_valid      <= 1'b0;
      resp_undef      <= 1'b0;
      resp_trap_el2   <= 1'b0;
      resp_trap_el3   <= 1'b0;
      resp_lower_pass <= 1'b0;
      resp_rdata      <= 64'h0000_0000_0000_0000;
    end else begin
      resp_valid      <= fire;
      resp_undef      <= fire && dec_undef;
      resp_trap_el2   <= fire && dec_el2;
      resp_trap_el3   <= fire && dec_el3;
      resp_lower_pass <= fire && dec_pass;
      resp_rdata      <= fire ? rd_d : 64'h0000_0000_0000_0000;
    end
  end

  // ---------------------------------------------------------------- labels
  // labels are registered, so they follow a change of level or enable by one cycle
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      data_partition_id   <= plr_pkg::DEF_PID;
      instr_partition_id  <= plr_pkg::DEF_PID;
      data_monitor_group  <= plr_pkg::DEF_PMG;
      instr_monitor_group <= plr_pkg::DEF_PMG;
    end else if (!label_enable_q || (cur_el == plr_pkg::EL2 && !el2_en)) begin
      data_partition_id   <= plr_pkg::DEF_PID;
      instr_partition_id  <= plr_pkg::DEF_PID;
      data_monitor_group  <= plr_pkg::DEF_PMG;
      instr_monitor_group <= plr_pkg::DEF_PMG;
    end else if (cur_el == plr_pkg::EL3) begin
      data_partition_id   <= mon_fields[plr_pkg::DPID_HI:plr_pkg::DPID_LO];
      instr_partition_id  <= mon_fields[plr_pkg::IPID_HI:plr_pkg::IPID_LO];
      data_monitor_group  <= mon_fields[plr_pkg::DPMG_HI:plr_pkg::DPMG_LO];
      instr_monitor_group <= mon_fields[plr_pkg::IPMG_HI:plr_pkg::IPMG_LO];
    end else if (cur_el == plr_pkg::EL2) begin
      data_partition_id   <= hyp_fields[plr_pkg::DPID_HI:plr_pkg::DPID_LO];
      instr_partition_id  <= hyp_fields[plr_pkg::IPID_HI:plr_pkg::IPID_LO];
      data_monitor_group  <= hyp_fields[plr_pkg::DPMG_HI:plr_pkg::DPMG_LO];
      instr_monitor_group <= hyp_fields[plr_pkg::IPMG_HI:plr_pkg::IPMG_LO];
    end else begin
      data_partition_id   <= lower_fields[plr_pkg::DPID_HI:plr_pkg::DPID_LO];
      instr_partition_id  <= lower_fields[plr_pkg::IPID_HI:plr_pkg::IPID_LO];
      data_monitor_group  <= lower_fields[plr_pkg::DPMG_HI:plr_pkg::DPMG_LO];
      instr_monitor_group <= lower_fields[plr_pkg::IPMG_HI:plr_pkg::IPMG_LO];
    end
  end

  assign label_enable = label_enable_q;

  // ---------------------------------------------------------------- checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  chk_default_label: assert property (!label_enable_q |=> (data_partition_id == plr_pkg::DEF_PID)
    && (instr_monitor_group == plr_pkg::DEF_PMG))
    else $error("labels not default while disabled");
  chk_hyp_enable_ro: assert property (hyp_wr && EL3_IMPL |=> $stable(label_enable_q))
    else $error("hypervisor write changed enable");
  chk_shared_read: assert property (fire && !req_write && (dec_hyp || dec_mon)
    |=> resp_rdata[63] == $past(label_enable_q))
    else $error("enable read differs from shared bit");
  chk_reset_state: assert property ($rose(rst_n) |-> !label_enable_q && (force_trap_q == 1'b1)
    && trap_user_q && trap_kern_q)
    else $error("bad reset values");
  chk_user_trap: assert property (fire && enc_user && req_el == plr_pkg::EL1 && !ft && el2_ctx
    && trap_user_q |=> resp_trap_el2 && !resp_lower_pass)
    else $error("user register access not trapped");
  chk_kern_trap: assert property (fire && enc_kern && req_el == plr_pkg::EL1 && !ft && el2_ctx
    && trap_kern_q && !nested_virtualization |=> resp_trap_el2)
    else $error("kernel register access not trapped");
  chk_force_trap: assert property (fire && EXT_IMPL && EL2_IMPL && enc_hyp
    && req_el == plr_pkg::EL2 && ft |=> resp_trap_el3 && !resp_trap_el2)
    else $error("forced trap to EL3 missing");
  chk_nested_trap: assert property (fire && EXT_IMPL && EL2_IMPL && enc_hyp
    && req_el == plr_pkg::EL1 && !ft && el2_ctx && host_in_hypervisor_mode
    && nested_virtualization && !nested_virt_redirect |=> resp_trap_el2)
    else $error("nested hypervisor access not trapped");
  chk_mon_lower: assert property (fire && enc_mon && req_el != plr_pkg::EL3 |=> resp_undef)
    else $error("monitor register reached below EL3");
  chk_el3_label: assert property (label_enable_q && cur_el == plr_pkg::EL3 && $stable(mon_fields)
    |=> data_partition_id == $past(mon_fields[31:16]))
    else $error("EL3 data label wrong");
  chk_answer_once: assert property (fire |=> resp_valid ##1 !resp_valid || $past(fire))
    else $error("answer strobe misplaced");

  cov_trap_el3: cover property (resp_valid && resp_trap_el3);
  cov_trap_el2: cover property (resp_valid && resp_trap_el2);
  cov_enable_on: cover property ($rose(label_enable_q) ##1 label_enable_q);

endmodule : plr_regs
`default_nettype wire

// *** plr_core_model.sv ***
// plr_core_model: core side that encodes which label register a move names
// assumes: combinational; the bench picks the register, this model forms the move's encoding
`timescale 1ns/100ps
`default_nettype none
module plr_core_model (
  input  wire logic [1:0] reg_sel,  // 0 kernel, 1 user, 2 hypervisor, 3 monitor
  output logic      [1:0] op0,      // encoding fields toward the register block
  output logic      [2:0] op1,
  output logic      [3:0] crn,
  output logic      [3:0] crm,
  output logic      [2:0] op2
);
  // shared fields are the same for all four label registers
  assign op0 = 2'h3;
  assign crn = 4'hA;
  assign crm = 4'h5;
  // op1 tells the levels apart; op2 alone picks out the user register
  assign op1 = (reg_sel == 2'h2) ? 3'h4 : ((reg_sel == 2'h3) ? 3'h6 : 3'h0);
  assign op2 = (reg_sel == 2'h1) ? plr_pkg::ENC_OP2_USER : 3'h0;
endmodule : plr_core_model
`default_nettype wire

// *** plr_regs_tb.sv ***
// plr_regs_tb: self-checking bench for the hypervisor and monitor label registers
// assumes: plr_regs with all levels present, plr_core_model forming each encoding
`timescale 1ns/100ps
`default_nettype none
module plr_regs_tb;
  logic        sys_clk, resetn, req_valid, req_write, ns, valid, undef, t2, t3, pass, en;  // clock, reset, strobes
  logic [1:0]  req_el, reg_sel, cur_el, op0;  // issuing level, register choice, running level
  logic [2:0]  op1, op2;                      // encoding from the core model
  logic [3:0]  crn, crm;
  logic [63:0] req_wdata, rdata;              // move data
  logic [47:0] lower_fields;                  // fields of the lower register in use
  logic [15:0] dpid, ipid;                    // labels seen on memory requests
  logic [7:0]  dpmg, ipmg;
  logic        sec_hyp, host, nv, redir;      // hypervisor context levels
  int          failures, n_compared, cycles;  // verdict counters and hang guard
  plr_core_model plr_core_model_inst (.reg_sel(reg_sel), .op0(op0), .op1(op1), .crn(crn), .crm(crm), .op2(op2));
  plr_regs plr_regs_inst (.sys_clk(sys_clk), .resetn(resetn), .req_valid(req_valid), .req_write(req_write),
    .req_el(req_el), .req_op0(op0), .req_op1(op1), .req_crn(crn), .req_crm(crm), .req_op2(op2),
    .req_wdata(req_wdata), .nonsecure_state(ns), .secure_hypervisor_enable(sec_hyp), .el2_uses_64(1'b1),
    .host_in_hypervisor_mode(host), .nested_virtualization(nv), .nested_virt_redirect(redir),
    .cur_el(cur_el), .lower_fields(lower_fields), .resp_valid(valid), .resp_undef(undef), .resp_trap_el2(t2),
    .resp_trap_el3(t3), .resp_lower_pass(pass), .resp_rdata(rdata), .label_enable(en),
    .data_partition_id(dpid), .instr_partition_id(ipid), .data_monitor_group(dpmg), .instr_monitor_group(ipmg));
  always #10 sys_clk = ~sys_clk;  // 20 ns period
  // hang guard: a stuck run still reaches the verdict
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      final_report();
    end
  end
  task automatic check(input string name, input logic [63:0] exp, input logic [63:0] got);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  // one move: a single-cycle request, answer judged in the cycle it stands
  task automatic move(input logic [1:0] sel, el, input logic wr, input logic [63:0] wd, input logic [4:0] exp);
    @(negedge sys_clk);
    reg_sel = sel;
    req_el = el;
    req_write = wr;
    req_wdata = wd;
    req_valid = 1'b1;
    @(negedge sys_clk);
    req_valid = 1'b0;
    check("resp", {59'h0, exp}, {59'h0, valid, undef, t2, t3, pass});
  endtask : move
  // labels are registered, so let two edges pass before looking
  task automatic labels(input logic [1:0] el, input logic [47:0] exp);
    cur_el = el;
    repeat (2) @(negedge sys_clk);
    check("labels", {16'h0, exp}, {16'h0, dpmg, ipmg, dpid, ipid});
  endtask : labels
  task automatic t_reset;
    labels(2'h1, 48'h0);
    move(2'h3, 2'h3, 1'b0, 64'h0, 5'h10);
    check("mon_rd", 64'h4000_0000_0000_0000, rdata);
    move(2'h2, 2'h3, 1'b0, 64'h0, 5'h10);
    check("hyp_rd", 64'h0003_0000_0000_0000, rdata);
  endtask : t_reset
  // refusals and forced traps while the force bit still holds its reset value
  task automatic t_refuse;
    move(2'h2, 2'h1, 1'b0, 64'h0, 5'h18);
    move(2'h3, 2'h2, 1'b0, 64'h0, 5'h18);
    move(2'h2, 2'h2, 1'b1, 64'h0, 5'h12);
    move(2'h0, 2'h1, 1'b0, 64'h0, 5'h12);
  endtask : t_refuse
  task automatic t_monitor;
    move(2'h3, 2'h3, 1'b1, 64'hFFFF_1234_5678_9ABC, 5'h10);
    move(2'h3, 2'h3, 1'b0, 64'h0, 5'h10);
    check("mon_rd", 64'hC000_1234_5678_9ABC, rdata);
    check("enable", 64'h1, {63'h0, en});
    move(2'h3, 2'h3, 1'b1, 64'h8000_1234_5678_9ABC, 5'h10);
    labels(2'h3, 48'h1234_5678_9ABC);
  endtask : t_monitor
  // hypervisor enable is read-only with a monitor level; traps reach EL2 only in context
  task automatic t_hyp;
    move(2'h2, 2'h2, 1'b1, 64'h7FFF_ABCD_1111_2222, 5'h10);
    move(2'h2, 2'h2, 1'b0, 64'h0, 5'h10);
    check("hyp_rd", 64'h8003_ABCD_1111_2222, rdata);
    labels(2'h2, 48'hABCD_1111_2222);
    move(2'h1, 2'h1, 1'b0, 64'h0, 5'h14);
    move(2'h0, 2'h1, 1'b0, 64'h0, 5'h14);
    labels(2'h1, 48'h5A5A_C3C3_0F0F);
    ns = 1'b0;
    labels(2'h2, 48'h0);
    move(2'h1, 2'h1, 1'b0, 64'h0, 5'h11);
  endtask : t_hyp
  // nested and host modes through secure EL2, force bit clear and then set again
  task automatic t_nested;
    {sec_hyp, host, nv} = 3'h7;
    move(2'h2, 2'h1, 1'b0, 64'h0, 5'h14);
    move(2'h0, 2'h2, 1'b0, 64'h0, 5'h10);
    check("alias_rd", 64'h8003_ABCD_1111_2222, rdata);
    move(2'h3, 2'h3, 1'b1, 64'hC000_1234_5678_9ABC, 5'h10);
    move(2'h2, 2'h1, 1'b0, 64'h0, 5'h12);
    move(2'h1, 2'h2, 1'b0, 64'h0, 5'h12);
    redir = 1'b1;
    move(2'h0, 2'h1, 1'b0, 64'h0, 5'h11);
    move(2'h2, 2'h1, 1'b0, 64'h0, 5'h18);
  endtask : t_nested
  task automatic final_report;
    if (failures == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : final_report
  initial begin
    {sys_clk, resetn, req_valid, req_write, req_el, reg_sel, cur_el, req_wdata} = '0;
    {sec_hyp, host, nv, redir} = '0;
    {failures, n_compared, cycles} = '0;
    ns = 1'b1;
    lower_fields = 48'h5A5A_C3C3_0F0F;
    repeat (5) @(negedge sys_clk);
    resetn = 1'b1;
    repeat (4) @(negedge sys_clk);
    t_reset();
    t_refuse();
    t_monitor();
    t_hyp();
    t_nested();
    final_report();
  end
endmodule : plr_regs_tb
`default_nettype wire
